/* File: logic/timer_pkg.sv */
package timer_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_COUNT = 8'hEA;
  localparam logic [7:0] IDX_CTRL  = 8'hEB;
  localparam logic [7:0] IDX_CCTL0 = 8'hEC;
  localparam logic [7:0] IDX_CVAL0 = 8'hED;
  localparam logic [7:0] IDX_CCTL1 = 8'hEE;
  localparam logic [7:0] IDX_CVAL1 = 8'hEF;
  localparam logic [7:0] IDX_FLAGS = 8'hF0;

  localparam logic [7:0] CTRL_RST  = 8'h08;
  localparam logic [7:0] CCTL_RST  = 8'h40;
  localparam logic [7:0] CVAL_RST  = 8'h00;
  localparam logic [7:0] CNT_ZERO  = 8'h00;
  localparam logic [7:0] CNT_ONE   = 8'h01;
  localparam logic [7:0] CNT_MAX   = 8'hFF;
  localparam logic [6:0] PRE_ZERO  = 7'h00;
  localparam logic [6:0] PRE_ONE   = 7'h01;

  typedef enum logic [1:0] {
    MODE_FREE = 2'b00,
    MODE_DOWN = 2'b01,
    MODE_MOD  = 2'b10,
    MODE_UPDN = 2'b11
  } timer_mode_t;

  typedef enum logic [2:0] {
    ACT_SET     = 3'b000,
    ACT_CLR     = 3'b001,
    ACT_TGL     = 3'b010,
    ACT_UP_SET  = 3'b011,
    ACT_UP_CLR  = 3'b100,
    ACT_REF_SET = 3'b101,
    ACT_REF_CLR = 3'b110,
    ACT_RSV     = 3'b111
  } action_t;

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } count_dir_t;

  typedef struct packed {
    logic [2:0]  div;
    logic        run;
    logic        overflow_irq_mask;
    logic        counter_clear;
    timer_mode_t mode;
  } timer_ctrl_t;

  typedef struct packed {
    logic       unused;
    logic       channel_irq_mask;
    action_t    output_action_select;
    logic       enable;
    logic [1:0] reserved;
  } chan_ctrl_t;

  typedef struct packed {
    logic [4:0] unused;
    logic       channel1_pending_flag;
    logic       channel0_pending_flag;
    logic       overflow_pending_flag;
  } flags_t;
endpackage

/* File: logic/eight_bit_timer_two_compare.sv */
`timescale 1ns/10ps
module eight_bit_timer_two_compare (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // System tick enable, one cycle per tick
  input  wire logic        system_tick_rate,
  // Compare outputs
  output logic             ch0_out,
  output logic             ch1_out,
  // Interrupt requests
  output logic             overflow_irq,
  output logic             ch0_irq,
  output logic             ch1_irq
);

  typedef struct packed {
    logic [6:0]                  pre;
    logic [7:0]                  count_register;
    timer_pkg::count_dir_t       dir;
    timer_pkg::timer_ctrl_t      ctrl;
    timer_pkg::chan_ctrl_t [1:0] cctl;
    logic [1:0][7:0]             compare_value;
    timer_pkg::flags_t           flags;
    logic [1:0]                  outs;
    logic [2:0]                  irq;
    logic [31:0]                 rdata;
    logic                        ready;
    logic                        err;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic logic [6:0] div_mask(input logic [2:0] d);
    div_mask = 7'((8'h01 << d) - 8'h01);
  endfunction

  function automatic logic known_index(input logic [7:0] i);
    known_index = (i >= timer_pkg::IDX_COUNT) && (i <= timer_pkg::IDX_FLAGS);
  endfunction

  // Output action of one channel for one counter step
  function automatic logic chan_next(
    input timer_pkg::action_t     act,
    input logic                   cur,
    input logic                   match,
    input logic                   zero,
    input logic                   ref_match,
    input timer_pkg::count_dir_t  dir,
    input logic                   updn
  );
    logic o;
    o = cur;
    case (act)
      timer_pkg::ACT_SET: begin
        if (match) o = 1'b1;
      end
      timer_pkg::ACT_CLR: begin
        if (match) o = 1'b0;
      end
      timer_pkg::ACT_TGL: begin
        if (match) o = ~cur;
      end
      timer_pkg::ACT_UP_SET: begin
        if (match && dir == timer_pkg::DIR_UP) o = 1'b1;
        else if (updn ? (match && dir == timer_pkg::DIR_DOWN) : zero) o = 1'b0;
      end
      timer_pkg::ACT_UP_CLR: begin
        if (match && dir == timer_pkg::DIR_UP) o = 1'b0;
        else if (updn ? (match && dir == timer_pkg::DIR_DOWN) : zero) o = 1'b1;
      end
      timer_pkg::ACT_REF_SET: begin
        if (match) o = 1'b1;
        else if (ref_match) o = 1'b0;
      end
      timer_pkg::ACT_REF_CLR: begin
        if (match) o = 1'b0;
        else if (ref_match) o = 1'b1;
      end
      timer_pkg::ACT_RSV: begin
        o = cur;
      end
      default: begin
        o = cur;
      end
    endcase
    chan_next = o;
  endfunction

  logic [7:0] idx;
  logic       wr;
  logic       rd_phase;
  logic       advance;
  logic       ovf_ev;
  logic       zero;
  logic       updn;
  logic [1:0] match;
  logic [1:0] ref_match;
  logic [7:0] wbyte;
  timer_pkg::timer_ctrl_t wctrl;
  timer_pkg::flags_t      wflags;

  assign idx   = paddr[9:2];
  assign wbyte = pwdata[7:0];
  assign wctrl = timer_pkg::timer_ctrl_t'(wbyte);
  assign wflags = timer_pkg::flags_t'(wbyte);
  // Writes land on the edge where pready is seen high
  assign wr       = psel && penable && pwrite && st.ready;
  assign rd_phase = psel && penable && !st.ready;

  always_comb begin
    next_st   = st;
    advance   = 1'b0;
    ovf_ev    = 1'b0;
    zero      = (st.count_register == timer_pkg::CNT_ZERO);
    updn      = (st.ctrl.mode == timer_pkg::MODE_UPDN);
    match     = '0;
    ref_match = '0;

    // APB answer one cycle into the access phase
    next_st.ready = rd_phase;
    // Error stands only with its pready pulse
    next_st.err   = 1'b0;
    if (rd_phase) begin
      next_st.err   = !known_index(idx) || paddr[11:10] != 2'b00;
      next_st.rdata = '0;
      if (!pwrite) begin
        case (idx)
          timer_pkg::IDX_COUNT: next_st.rdata[7:0] = st.count_register;
          timer_pkg::IDX_CTRL:  next_st.rdata[7:0] = st.ctrl;
          timer_pkg::IDX_CCTL0: next_st.rdata[7:0] = st.cctl[0];
          timer_pkg::IDX_CVAL0: next_st.rdata[7:0] = st.compare_value[0];
          timer_pkg::IDX_CCTL1: next_st.rdata[7:0] = st.cctl[1];
          timer_pkg::IDX_CVAL1: next_st.rdata[7:0] = st.compare_value[1];
          timer_pkg::IDX_FLAGS: next_st.rdata[7:0] = st.flags;
          default:              next_st.rdata = '0;
        endcase
      end
    end

    // Prescaler
    if (st.ctrl.run && system_tick_rate) begin
      next_st.pre = 7'(st.pre + timer_pkg::PRE_ONE);
      advance = (st.pre & div_mask(st.ctrl.div)) == div_mask(st.ctrl.div);
    end

    for (int c = 0; c < 2; c++) begin
      match[c] = advance && (st.count_register == st.compare_value[c]);
      ref_match[c] = (c == 0) ? (advance && zero) : match[0];
    end

    // Counter step
    if (advance) begin
      case (st.ctrl.mode)
        timer_pkg::MODE_FREE: begin
          next_st.dir = timer_pkg::DIR_UP;
          next_st.count_register = 8'(st.count_register + timer_pkg::CNT_ONE);
          ovf_ev = (st.count_register == timer_pkg::CNT_MAX);
        end
        timer_pkg::MODE_DOWN: begin
          next_st.dir = timer_pkg::DIR_DOWN;
          if (!zero) begin
            next_st.count_register = 8'(st.count_register - timer_pkg::CNT_ONE);
            ovf_ev = (st.count_register == timer_pkg::CNT_ONE);
          end
        end
        timer_pkg::MODE_MOD: begin
          next_st.dir = timer_pkg::DIR_UP;
          if (st.count_register == st.compare_value[0]) begin
            next_st.count_register = timer_pkg::CNT_ZERO;
            ovf_ev = 1'b1;
          end else begin
            next_st.count_register = 8'(st.count_register + timer_pkg::CNT_ONE);
          end
        end
        timer_pkg::MODE_UPDN: begin
          if (st.dir == timer_pkg::DIR_UP) begin
            if (st.count_register == st.compare_value[0]) begin
              next_st.dir = timer_pkg::DIR_DOWN;
              if (!zero) next_st.count_register = 8'(st.count_register - timer_pkg::CNT_ONE);
            end else begin
              next_st.count_register = 8'(st.count_register + timer_pkg::CNT_ONE);
            end
          end else if (zero) begin
            next_st.dir = timer_pkg::DIR_UP;
            ovf_ev = 1'b1;
            if (st.compare_value[0] != timer_pkg::CNT_ZERO) begin
              next_st.count_register = timer_pkg::CNT_ONE;
            end
          end else begin
            next_st.count_register = 8'(st.count_register - timer_pkg::CNT_ONE);
          end
        end
        default: next_st.count_register = st.count_register;
      endcase
    end

    // Channel outputs act only while compare is enabled
    for (int c = 0; c < 2; c++) begin
      if (st.cctl[c].enable) begin
        next_st.outs[c] = chan_next(st.cctl[c].output_action_select, st.outs[c],
                                    match[c], advance && zero, ref_match[c], st.dir, updn);
      end
    end

    // Register writes
    next_st.ctrl.counter_clear = 1'b0;
    if (wr) begin
      case (idx)
        timer_pkg::IDX_CTRL: begin
          next_st.ctrl = wctrl;
          next_st.ctrl.counter_clear = 1'b0;
          // Down mode reloads from compare 0 when started
          if (wctrl.run && !st.ctrl.run && wctrl.mode == timer_pkg::MODE_DOWN) begin
            next_st.count_register = st.compare_value[0];
          end
          if (wctrl.counter_clear) begin
            next_st.count_register = timer_pkg::CNT_ZERO;
            next_st.dir = timer_pkg::DIR_UP;
          end
        end
        timer_pkg::IDX_CCTL0: next_st.cctl[0] = timer_pkg::chan_ctrl_t'({1'b0, wbyte[6:0]});
        timer_pkg::IDX_CVAL0: next_st.compare_value[0] = wbyte;
        timer_pkg::IDX_CCTL1: next_st.cctl[1] = timer_pkg::chan_ctrl_t'({1'b0, wbyte[6:0]});
        timer_pkg::IDX_CVAL1: next_st.compare_value[1] = wbyte;
        default: next_st.ctrl.counter_clear = 1'b0;
      endcase
    end

    // Pending flags: write zero clears, a same-cycle event wins
    if (wr && idx == timer_pkg::IDX_FLAGS) begin
      next_st.flags.overflow_pending_flag =
        st.flags.overflow_pending_flag & wflags.overflow_pending_flag;
      next_st.flags.channel0_pending_flag =
        st.flags.channel0_pending_flag & wflags.channel0_pending_flag;
      next_st.flags.channel1_pending_flag =
        st.flags.channel1_pending_flag & wflags.channel1_pending_flag;
    end
    next_st.flags.unused = '0;
    if (ovf_ev) next_st.flags.overflow_pending_flag = 1'b1;
    if (match[0] && st.cctl[0].enable) next_st.flags.channel0_pending_flag = 1'b1;
    if (match[1] && st.cctl[1].enable) next_st.flags.channel1_pending_flag = 1'b1;

    next_st.irq[0] = next_st.flags.overflow_pending_flag
                     && next_st.ctrl.overflow_irq_mask;
    next_st.irq[1] = next_st.flags.channel0_pending_flag
                     && next_st.cctl[0].channel_irq_mask;
    next_st.irq[2] = next_st.flags.channel1_pending_flag
                     && next_st.cctl[1].channel_irq_mask;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st               <= '0;
      st.ctrl          <= timer_pkg::timer_ctrl_t'(timer_pkg::CTRL_RST);
      st.cctl[0]       <= timer_pkg::chan_ctrl_t'(timer_pkg::CCTL_RST);
      st.cctl[1]       <= timer_pkg::chan_ctrl_t'(timer_pkg::CCTL_RST);
      st.compare_value <= {timer_pkg::CVAL_RST, timer_pkg::CVAL_RST};
    end else begin
      st <= next_st;
    end
  end

  assign prdata       = st.rdata;
  assign pready       = st.ready;
  assign pslverr      = st.err;
  assign ch0_out      = st.outs[0];
  assign ch1_out      = st.outs[1];
  assign overflow_irq = st.irq[0];
  assign ch0_irq      = st.irq[1];
  assign ch1_irq      = st.irq[2];

endmodule

/* File: verif/eight_bit_timer_two_compare_sva.sv */
`timescale 1ns/10ps
module eight_bit_timer_two_compare_sva (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Timer pins
  input wire logic        system_tick_rate,
  input wire logic        ch0_out,
  input wire logic        ch1_out,
  input wire logic        overflow_irq,
  input wire logic        ch0_irq,
  input wire logic        ch1_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = paddr[11:10] == 2'b00 && paddr[9:2] >= timer_pkg::IDX_COUNT
                  && paddr[9:2] <= timer_pkg::IDX_FLAGS;
  property p_wait;
    psel && !penable ##1 psel && penable |=> pready;
  endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait state");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than a cycle");
  property p_err;
    pslverr |-> pready && !mapped;
  endproperty
  a_err: assert property (p_err) else $error("error on a mapped access");
  property p_unmapped;
    pready && !mapped && !pwrite |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  property p_upper;
    pready && !pwrite |-> prdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_clr_rd;
    pready && !pwrite && mapped && paddr[9:2] == timer_pkg::IDX_CTRL |-> !prdata[2];
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clear bit reads one");
  property p_out_hold;
    !system_tick_rate |=> $stable(ch0_out) && $stable(ch1_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved without a tick");
  // Two quiet cycles, though a mask write already reaches the irq on its own edge
  property p_irq_hold;
    !system_tick_rate && !psel ##1 !system_tick_rate && !psel
      |=> $stable({overflow_irq, ch0_irq, ch1_irq});
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq moved while idle");
  property p_irq_rise;
    $rose(overflow_irq) || $rose(ch0_irq) || $rose(ch1_irq)
      |-> $past(system_tick_rate) || $past(psel) || $past(psel, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq raised with no cause");
  c_ch0: cover property ($rose(ch0_out));
  c_ch1: cover property ($rose(ch1_out));
  c_ovf: cover property ($rose(overflow_irq));
endmodule

bind eight_bit_timer_two_compare eight_bit_timer_two_compare_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .system_tick_rate(system_tick_rate), .ch0_out(ch0_out), .ch1_out(ch1_out),
  .overflow_irq(overflow_irq), .ch0_irq(ch0_irq), .ch1_irq(ch1_irq)
);

/* File: verif/eight_bit_timer_two_compare_tb_top.sv */
`timescale 1ns/10ps
module eight_bit_timer_two_compare_tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        system_tick_rate;
  logic        ch0_out;
  logic        ch1_out;
  logic        overflow_irq;
  logic        ch0_irq;
  logic        ch1_irq;
  logic [31:0] rdat;
  logic        rerr;
  int          failures;
  int          tests_run;
  // Channel control with the unused action and compare enabled
  localparam logic [7:0] HOLD = 8'h7C;

  eight_bit_timer_two_compare DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .system_tick_rate(system_tick_rate), .ch0_out(ch0_out), .ch1_out(ch1_out),
    .overflow_irq(overflow_irq), .ch0_irq(ch0_irq), .ch1_irq(ch1_irq)
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Request held from setup until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      failures++;
      wrap_up();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the completing edge settle before callers look at outputs
    #1;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input string nm, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(nm, {24'h0, e}, rdat);
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge pclk) system_tick_rate <= 1'b1;
    @(posedge pclk) system_tick_rate <= 1'b0;
    @(posedge pclk);
  endtask

  // Reserved low bits always written as zero
  function automatic logic [7:0] cc(input logic [2:0] a, input logic en, input logic m);
    return {1'b0, m, a, en, 2'b00};
  endfunction

  task automatic t_reset;
    rd(timer_pkg::IDX_COUNT, "count", timer_pkg::CNT_ZERO);
    rd(timer_pkg::IDX_CTRL, "ctrl", timer_pkg::CTRL_RST);
    rd(timer_pkg::IDX_CCTL0, "cctl0", timer_pkg::CCTL_RST);
    rd(timer_pkg::IDX_CVAL0, "cval0", timer_pkg::CVAL_RST);
    rd(timer_pkg::IDX_CCTL1, "cctl1", timer_pkg::CCTL_RST);
    rd(timer_pkg::IDX_CVAL1, "cval1", timer_pkg::CVAL_RST);
    rd(timer_pkg::IDX_FLAGS, "flags", 8'h00);
    rd(8'h40, "unmapped", 8'h00);
    chk("unmapped err", 32'h1, 32'(rerr));
  endtask

  task automatic t_prescale;
    for (int d = 0; d < 8; d++) begin
      wr(timer_pkg::IDX_CTRL, {d[2:0], 5'h1C});
      ticks(256);
      rd(timer_pkg::IDX_COUNT, "count", 8'(256 >> d));
    end
    chk("ovf irq", 32'h1, 32'(overflow_irq));
    rd(timer_pkg::IDX_FLAGS, "flags", 8'h01);
    wr(timer_pkg::IDX_FLAGS, 8'h00);
    chk("ovf irq", 32'h0, 32'(overflow_irq));
    wr(timer_pkg::IDX_CTRL, 8'h14);
    ticks(256);
    chk("masked irq", 32'h0, 32'(overflow_irq));
    rd(timer_pkg::IDX_FLAGS, "flags", 8'h01);
    wr(timer_pkg::IDX_FLAGS, 8'h00);
  endtask

  task automatic t_hold;
    wr(timer_pkg::IDX_CTRL, 8'h1C);
    ticks(10);
    wr(timer_pkg::IDX_CTRL, 8'h08);
    ticks(5);
    rd(timer_pkg::IDX_COUNT, "stopped", 8'h0A);
    wr(timer_pkg::IDX_COUNT, 8'h55);
    rd(timer_pkg::IDX_COUNT, "ro count", 8'h0A);
    wr(timer_pkg::IDX_CTRL, 8'h0C);
    rd(timer_pkg::IDX_CTRL, "clr bit", 8'h08);
    rd(timer_pkg::IDX_COUNT, "cleared", 8'h00);
  endtask

  task automatic t_cmp(input logic [7:0] c0, input logic [7:0] c1, input int n,
                       input logic e0, input logic e1);
    wr(timer_pkg::IDX_CTRL, 8'h1C);
    wr(timer_pkg::IDX_CCTL0, c0);
    wr(timer_pkg::IDX_CCTL1, c1);
    ticks(n);
    chk("ch0_out", 32'(e0), 32'(ch0_out));
    chk("ch1_out", 32'(e1), 32'(ch1_out));
  endtask

  task automatic t_actions;
    wr(timer_pkg::IDX_CVAL0, 8'h05);
    wr(timer_pkg::IDX_CVAL1, 8'h03);
    t_cmp(cc(3'h0, 1, 1), HOLD, 6, 1, 0);
    chk("ch0 irq", 32'h1, 32'(ch0_irq));
    chk("ch1 irq", 32'h1, 32'(ch1_irq));
    wr(timer_pkg::IDX_CCTL0, cc(3'h0, 1, 0));
    chk("ch0 masked", 32'h0, 32'(ch0_irq));
    t_cmp(cc(3'h1, 1, 1), HOLD, 6, 0, 0);
    t_cmp(cc(3'h2, 1, 1), HOLD, 6, 1, 0);
    t_cmp(cc(3'h7, 1, 1), HOLD, 6, 1, 0);
    t_cmp(cc(3'h1, 0, 1), HOLD, 6, 1, 0);
    t_cmp(cc(3'h3, 1, 1), HOLD, 3, 0, 0);
    t_cmp(cc(3'h3, 1, 1), HOLD, 6, 1, 0);
    t_cmp(cc(3'h4, 1, 1), HOLD, 6, 0, 0);
    t_cmp(cc(3'h4, 1, 1), HOLD, 3, 1, 0);
    t_cmp(cc(3'h5, 1, 1), HOLD, 3, 0, 0);
    t_cmp(cc(3'h6, 1, 1), HOLD, 6, 0, 0);
    t_cmp(cc(3'h6, 1, 1), HOLD, 3, 1, 0);
    t_cmp(HOLD, cc(3'h6, 1, 1), 6, 1, 1);
    t_cmp(HOLD, cc(3'h5, 1, 1), 6, 1, 0);
    t_cmp(HOLD, cc(3'h5, 1, 1), 4, 1, 1);
  endtask

  task automatic t_modes;
    wr(timer_pkg::IDX_CTRL, 8'h1E);
    ticks(8);
    rd(timer_pkg::IDX_COUNT, "modulo", 8'h02);
    wr(timer_pkg::IDX_CVAL0, 8'h03);
    wr(timer_pkg::IDX_CTRL, 8'h1F);
    ticks(7);
    rd(timer_pkg::IDX_COUNT, "updown", 8'h01);
    wr(timer_pkg::IDX_CTRL, 8'h09);
    wr(timer_pkg::IDX_CTRL, 8'h19);
    ticks(2);
    rd(timer_pkg::IDX_COUNT, "down", 8'h01);
    ticks(4);
    rd(timer_pkg::IDX_COUNT, "down end", 8'h00);
  endtask

  initial begin
    failures = 0;
    tests_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    system_tick_rate = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_prescale();
    t_hold();
    t_actions();
    t_modes();
    wrap_up();
  end
endmodule
